/* File: rtl/bp_pkg.sv */
// Purpose: Shared constants and types for the battery protection controller
// Assumes: One 20 MHz clock; comparator inputs are asynchronous levels, synchronised in each qualifier
// Notes:   All times are kept in their own units; only the tick length is turned into clocks here
package bp_pkg;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 50;
   localparam int TICK_NS         = 1000;
   localparam int TICK_CYC        = TICK_NS / CLK_PERIOD_NS;
   localparam int US_PER_MS       = 1000;
   localparam int SC_STEP_US      = 61;
   localparam int OC_FIRST_US     = 1000;
   localparam int OC_STEP_US      = 2000;
   localparam int DUV_BASE_MS     = 750;
   localparam int DUV_STEP_MS     = 250;
   localparam int DUV_WARN_MS     = 250;
   localparam int HOLD_MS         = 1000;
   localparam int LOCK_WINDOW_CYC = 4;
   localparam int CNT_W           = 16;

   // ----------------------------------------------------------------------
   // Parameter register selects, field positions and reset values
   // ----------------------------------------------------------------------
   localparam logic [2:0] SEL_CTRL   = 3'h0;
   localparam logic [2:0] SEL_TIMING = 3'h1;
   localparam logic [2:0] SEL_OCLVL  = 3'h2;
   localparam logic [2:0] SEL_SCLVL  = 3'h3;
   localparam logic [2:0] SEL_DUV    = 3'h4;
   localparam int CTRL_CCD      = 0;
   localparam int CTRL_DCD      = 1;
   localparam int CTRL_SCD      = 2;
   localparam int CTRL_DUVD     = 3;
   localparam int TIM_OCPT_LSB  = 0;
   localparam int TIM_SCPT_LSB  = 4;
   localparam int OCL_CCDL_LSB  = 0;
   localparam int OCL_DCDL_LSB  = 4;
   localparam int SCL_SCDL_LSB  = 0;
   localparam int DUV_DUDL_LSB  = 0;
   localparam int DUV_UNDERVOLTAGE_DELAY_FIELD_LSB  = 4;
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] TIMING_RST = 8'h00;
   localparam logic [7:0] OCLVL_RST  = 8'h00;
   localparam logic [7:0] SCLVL_RST  = 8'h00;
   localparam logic [7:0] DUV_RST    = 8'h00;
   localparam logic [7:0] CTRL_MASK  = 8'h0F;
   localparam logic [7:0] SCLVL_MASK = 8'h0F;
   localparam logic [7:0] DUV_MASK   = 8'h3F;

   // ----------------------------------------------------------------------
   // Flag positions
   // ----------------------------------------------------------------------
   localparam int FLG_SC   = 0;
   localparam int FLG_DCOC = 1;
   localparam int FLG_CCOC = 2;
   localparam int FLG_DUVW = 3;
   localparam int FLG_EXIT = 4;
   localparam int FLG_N    = 5;

   typedef enum logic [1:0] {
      LK_OPEN,
      LK_ARMED,
      LK_LOCKED
   } bp_lock_t;

   typedef struct packed {
      logic duv;
      logic sc;
      logic dcoc;
      logic ccoc;
   } bp_cond_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] timing;
      logic [7:0] oclvl;
      logic [7:0] sclvl;
      logic [7:0] duv;
   } bp_cfg_t;

   typedef struct packed {
      logic       wr;
      logic [2:0] sel;
      logic [7:0] data;
   } bp_cfg_wr_t;

   typedef struct packed {
      logic discharge;
      logic charge;
      logic precharge;
   } bp_fet_t;

endpackage

/* File: rtl/bp_qual.sv */
// Purpose: Qualify one comparator condition against a programmed time
// Assumes: i_tick is a one-cycle enable at the qualification rate
// Notes:   Counter restarts whenever the condition or the enable drops
`timescale 1ns/100ps
module bp_qual (
   input  wire logic                     i_clk,     // System clock
   input  wire logic                     i_reset_n, // Async reset, active low
   input  wire logic                     i_clr,     // Synchronous restart
   input  wire logic                     i_en,      // Detection enabled
   input  wire logic                     i_raw,     // Comparator level
   input  wire logic                     i_tick,    // Sample enable
   input  wire logic [bp_pkg::CNT_W-1:0] i_limit,   // Time in ticks
   output logic      [bp_pkg::CNT_W-1:0] o_count,   // Ticks qualified so far
   output logic                          o_active,  // Condition present
   output logic                          o_fire     // Time exceeded, pulse
);

   logic                     meta_reg;
   logic                     sync_reg;
   logic [bp_pkg::CNT_W-1:0] cnt_reg;
   logic [bp_pkg::CNT_W-1:0] cnt_next;
   wire                      run = i_en & sync_reg;

   // ----------------------------------------------------------------------
   // Synchroniser and counter
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         cnt_reg  <= '0;
      end else begin
         meta_reg <= i_raw;
         sync_reg <= meta_reg;
         cnt_reg  <= cnt_next;
      end
   end

   // Saturates one past the limit so a steady fault fires only once
   always_comb begin
      if (i_clr || !run) begin
         cnt_next = '0;                                   // [RULE23]
      end else if (i_tick && cnt_reg <= i_limit) begin
         cnt_next = cnt_reg + 1'b1;
      end else begin
         cnt_next = cnt_reg;
      end
   end

   assign o_count  = cnt_reg;
   assign o_active = run;
   assign o_fire   = run & i_tick & (cnt_reg == i_limit) & ~i_clr;  // [RULE23]

endmodule

/* File: rtl/bp_top.sv */
// Purpose: Autonomous battery protection: under-voltage and current faults
// Assumes: Comparator outputs come from the analog front end; the sample
//          rate is derived from the system clock by a divider
// Notes:   US_PER_MS may be lowered in simulation to shorten all ms times
//
// Overview of operation
// [RULE1] Long under-voltage: switches off, enter power-off
// [RULE2] Warning flag 250 ms before power-off
// [RULE3] Power-off until charger, then full reinitialise
// [RULE4] Discharge over-current qualified by over-current time
// [RULE5] Charge over-current qualified by same time
// [RULE6] Short-circuit qualified by its own time
// [RULE7] Current fault drops switches, holds one second
// [RULE8] Discharge enable writes ignored during hold-off
// [RULE9] Software must re-enable both switches itself
// [RULE10] Re-enable under persisting fault trips again
// [RULE11] Each protection raises individually maskable interrupt
// [RULE12] Discharge switch off disables discharge detection
// [RULE13] Charge detection off only both switches off
// [RULE14] Charge detection always on under PWM
// [RULE15] Qualification runs on divided sample tick
// [RULE16] Three current levels, two reaction delays
// [RULE17] Under-voltage level and delay from own register
// [RULE18] Lock rejects parameter writes until reset
// [RULE19] Flags cleared by one; enabled flags ORed
// [RULE20] Same register not rewritten within 8 cycles
// [RULE21] Lock needs two-write sequence within four cycles
// [RULE22] Delay codes give 750 to 1500 ms
// [RULE23] Synchronise comparators; counters restart on release
// [RULE24] Exit interrupt; balancing off only on under-voltage
`timescale 1ns/100ps
module bp_top #(
   parameter int US_PER_MS = bp_pkg::US_PER_MS                   // Ticks per ms
) (
   input  wire logic                    i_clk,           // 20 MHz clock
   input  wire logic                    i_reset_n,       // Async reset, active low
   input  wire bp_pkg::bp_cond_t        i_cond,          // Comparator levels
   input  wire logic                    i_charger_det,   // Charger present
   input  wire logic                    i_pwm_active,    // Charge or precharge PWM
   input  wire bp_pkg::bp_cfg_wr_t      i_cfg_wr,        // Parameter write
   input  wire logic                    i_lock_wr,       // Lock register write
   input  wire logic                    i_param_lock_enable, // Lock enable bit
   input  wire logic                    i_param_lock,    // Lock bit
   input  wire logic                    i_fet_wr,        // Switch enable write
   input  wire bp_pkg::bp_fet_t         i_fet_data,      // Requested enables
   input  wire logic [bp_pkg::FLG_N-1:0] i_flag_clr,     // Write-one-to-clear
   input  wire logic [bp_pkg::FLG_N-1:0] i_irq_en,       // Interrupt enables
   output bp_pkg::bp_cfg_t              o_cfg,           // Parameter readback
   output logic                         o_locked,        // Parameters locked
   output bp_pkg::bp_fet_t              o_fet,           // Switch enables
   output logic                         o_balance_allow, // Cell balancing allowed
   output logic                         o_power_off,     // Chip in power-off
   output bp_pkg::bp_cond_t             o_det_en,        // Detector enables
   output logic [bp_pkg::FLG_N-1:0]     o_flags,         // Sticky flags
   output logic                         o_hold_active,   // Hold-off running
   output logic                         o_irq            // Interrupt request
);

   // ----------------------------------------------------------------------
   // Sample tick dividers
   // ----------------------------------------------------------------------
   logic [7:0]  us_div_reg;
   logic [15:0] ms_div_reg;
   wire us_tick = (us_div_reg == 8'(bp_pkg::TICK_CYC - 1));
   wire ms_tick = us_tick & (ms_div_reg == 16'(US_PER_MS - 1));
   logic restart;

   // Dividers run free of the CPU; the qualifiers only see these pulses
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         us_div_reg <= 8'h00;
         ms_div_reg <= 16'h0000;
      end else begin
         us_div_reg <= us_tick ? 8'h00 : us_div_reg + 8'h01;      // [RULE15]
         if (us_tick) begin
            ms_div_reg <= ms_tick ? 16'h0000 : ms_div_reg + 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Parameter lock
   // ----------------------------------------------------------------------
   bp_pkg::bp_lock_t lock_reg;
   bp_pkg::bp_lock_t lock_next;
   logic [2:0]       lock_win_reg;
   wire lock_first  = i_lock_wr & i_param_lock_enable & i_param_lock;
   wire lock_second = i_lock_wr & ~i_param_lock_enable & i_param_lock;

   always_comb begin
      case (lock_reg)
         bp_pkg::LK_OPEN: begin
            lock_next = lock_first ? bp_pkg::LK_ARMED : bp_pkg::LK_OPEN;
         end
         bp_pkg::LK_ARMED: begin
            if (lock_second) begin
               lock_next = bp_pkg::LK_LOCKED;                     // [RULE21]
            end else if (lock_first) begin
               lock_next = bp_pkg::LK_ARMED;
            end else if (i_lock_wr || lock_win_reg == 3'(bp_pkg::LOCK_WINDOW_CYC)) begin
               lock_next = bp_pkg::LK_OPEN;                       // [RULE21]
            end else begin
               lock_next = bp_pkg::LK_ARMED;
            end
         end
         bp_pkg::LK_LOCKED: lock_next = bp_pkg::LK_LOCKED;        // [RULE18]
         default:           lock_next = bp_pkg::LK_OPEN;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         lock_reg     <= bp_pkg::LK_OPEN;
         lock_win_reg <= 3'h0;
      end else begin
         lock_reg     <= restart ? bp_pkg::LK_OPEN : lock_next;
         lock_win_reg <= (lock_next == bp_pkg::LK_ARMED && !lock_first) ?
                         lock_win_reg + 3'h1 : 3'h0;
      end
   end

   assign o_locked = (lock_reg == bp_pkg::LK_LOCKED);

   // ----------------------------------------------------------------------
   // Parameter registers
   // ----------------------------------------------------------------------
   // Single clock, so a write lands at once; spacing writes is harmless
   bp_pkg::bp_cfg_t cfg_reg;
   wire cfg_ok = i_cfg_wr.wr & ~o_locked;                         // [RULE18]

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cfg_reg <= {bp_pkg::CTRL_RST, bp_pkg::TIMING_RST, bp_pkg::OCLVL_RST,
                     bp_pkg::SCLVL_RST, bp_pkg::DUV_RST};
      end else if (restart) begin
         cfg_reg <= {bp_pkg::CTRL_RST, bp_pkg::TIMING_RST, bp_pkg::OCLVL_RST,
                     bp_pkg::SCLVL_RST, bp_pkg::DUV_RST};
      end else if (cfg_ok) begin                                  // [RULE20]
         case (i_cfg_wr.sel)
            bp_pkg::SEL_CTRL:   cfg_reg.ctrl   <= i_cfg_wr.data & bp_pkg::CTRL_MASK;
            bp_pkg::SEL_TIMING: cfg_reg.timing <= i_cfg_wr.data;  // [RULE16]
            bp_pkg::SEL_OCLVL:  cfg_reg.oclvl  <= i_cfg_wr.data;  // [RULE16]
            bp_pkg::SEL_SCLVL:  cfg_reg.sclvl  <= i_cfg_wr.data & bp_pkg::SCLVL_MASK;
            bp_pkg::SEL_DUV:    cfg_reg.duv    <= i_cfg_wr.data & bp_pkg::DUV_MASK; // [RULE17]
            default:            cfg_reg        <= cfg_reg;
         endcase
      end
   end

   assign o_cfg = cfg_reg;

   // ----------------------------------------------------------------------
   // Reaction limits
   // ----------------------------------------------------------------------
   wire [3:0] ocpt = cfg_reg.timing[bp_pkg::TIM_OCPT_LSB +: 4];
   wire [3:0] scpt = cfg_reg.timing[bp_pkg::TIM_SCPT_LSB +: 4];
   wire [1:0] undervoltage_delay_field = cfg_reg.duv[bp_pkg::DUV_UNDERVOLTAGE_DELAY_FIELD_LSB +: 2];
   wire [bp_pkg::CNT_W-1:0] sc_lim =
      16'(bp_pkg::SC_STEP_US * (32'(scpt) + 1));                  // [RULE6]
   wire [bp_pkg::CNT_W-1:0] oc_lim = (ocpt == 4'h0) ? 16'(bp_pkg::OC_FIRST_US) :
      16'(bp_pkg::OC_STEP_US * 32'(ocpt));                        // [RULE4] [RULE5]
   wire [bp_pkg::CNT_W-1:0] duv_lim =
      16'(bp_pkg::DUV_BASE_MS + bp_pkg::DUV_STEP_MS * 32'(undervoltage_delay_field)); // [RULE22]

   // ----------------------------------------------------------------------
   // Detector enables
   // ----------------------------------------------------------------------
   bp_pkg::bp_fet_t fet_reg;
   logic            poff_reg;
   logic [15:0]     hold_reg;

   assign o_det_en.sc   = fet_reg.discharge & ~cfg_reg.ctrl[bp_pkg::CTRL_SCD];  // [RULE12]
   assign o_det_en.dcoc = fet_reg.discharge & ~cfg_reg.ctrl[bp_pkg::CTRL_DCD];  // [RULE12]
   assign o_det_en.ccoc = (fet_reg.charge | fet_reg.precharge | i_pwm_active) &
                          ~cfg_reg.ctrl[bp_pkg::CTRL_CCD];        // [RULE13] [RULE14]
   assign o_det_en.duv  = ~poff_reg & ~cfg_reg.ctrl[bp_pkg::CTRL_DUVD];

   // ----------------------------------------------------------------------
   // Qualifiers
   // ----------------------------------------------------------------------
   logic                     sc_fire;
   logic                     dcoc_fire;
   logic                     ccoc_fire;
   logic                     duv_fire;
   logic                     duv_act;
   logic [bp_pkg::CNT_W-1:0] duv_cnt;

   bp_qual u_sc (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_clr(restart),
      .i_en(o_det_en.sc), .i_raw(i_cond.sc), .i_tick(us_tick),
      .i_limit(sc_lim), .o_count(), .o_active(), .o_fire(sc_fire)  // [RULE6]
   );
   bp_qual u_dcoc (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_clr(restart),
      .i_en(o_det_en.dcoc), .i_raw(i_cond.dcoc), .i_tick(us_tick),
      .i_limit(oc_lim), .o_count(), .o_active(), .o_fire(dcoc_fire) // [RULE4]
   );
   bp_qual u_ccoc (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_clr(restart),
      .i_en(o_det_en.ccoc), .i_raw(i_cond.ccoc), .i_tick(us_tick),
      .i_limit(oc_lim), .o_count(), .o_active(), .o_fire(ccoc_fire) // [RULE5]
   );
   bp_qual u_duv (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_clr(restart),
      .i_en(o_det_en.duv), .i_raw(i_cond.duv), .i_tick(ms_tick),
      .i_limit(duv_lim), .o_count(duv_cnt), .o_active(duv_act),
      .o_fire(duv_fire)                                            // [RULE1]
   );

   wire cur_trip = sc_fire | dcoc_fire | ccoc_fire;
   wire duv_warn = duv_act & ms_tick &
                   (duv_cnt == duv_lim - 16'(bp_pkg::DUV_WARN_MS)); // [RULE2]

   // ----------------------------------------------------------------------
   // Switch control, hold-off and power-off
   // ----------------------------------------------------------------------
   // Charger restarts the block as a power-up would; the async reset
   // remains the only path to reset the tick dividers, lock window and synchronisers
   assign restart = poff_reg & i_charger_det;                      // [RULE3]
   wire hold_end  = (hold_reg == 16'h0001) & ms_tick;
   wire fet_take  = i_fet_wr & (hold_reg == 16'h0000) & ~poff_reg; // [RULE8] [RULE9]

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         fet_reg  <= '0;
         poff_reg <= 1'b0;
         hold_reg <= 16'h0000;
      end else if (restart) begin
         fet_reg  <= '0;
         poff_reg <= 1'b0;
         hold_reg <= 16'h0000;
      end else begin
         if (duv_fire || poff_reg) begin
            fet_reg  <= '0;                                        // [RULE1]
            poff_reg <= 1'b1;                                      // [RULE3]
         end else if (cur_trip) begin
            fet_reg  <= '0;                                        // [RULE7] [RULE10]
         end else if (fet_take) begin
            fet_reg  <= i_fet_data;
         end
         if (cur_trip) begin
            hold_reg <= 16'(bp_pkg::HOLD_MS + 1);  // [RULE7] first tick may be early
         end else if (ms_tick && hold_reg != 16'h0000) begin
            hold_reg <= hold_reg - 16'h0001;
         end
      end
   end

   assign o_fet           = fet_reg;
   assign o_power_off     = poff_reg;
   assign o_hold_active   = (hold_reg != 16'h0000);
   assign o_balance_allow = ~poff_reg;                             // [RULE24]

   // ----------------------------------------------------------------------
   // Flags and interrupt
   // ----------------------------------------------------------------------
   logic [bp_pkg::FLG_N-1:0] flag_reg;
   logic [bp_pkg::FLG_N-1:0] flag_set;

   always_comb begin
      flag_set                   = '0;
      flag_set[bp_pkg::FLG_SC]   = sc_fire;
      flag_set[bp_pkg::FLG_DCOC] = dcoc_fire;
      flag_set[bp_pkg::FLG_CCOC] = ccoc_fire;
      flag_set[bp_pkg::FLG_DUVW] = duv_warn;                       // [RULE2]
      flag_set[bp_pkg::FLG_EXIT] = hold_end & ~cur_trip;           // [RULE24]
   end

   // Set wins over a clear in the same cycle so no event is lost
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         flag_reg <= '0;
      end else if (restart) begin
         flag_reg <= '0;
      end else begin
         flag_reg <= (flag_reg & ~i_flag_clr) | flag_set;          // [RULE19]
      end
   end

   assign o_flags = flag_reg;
   assign o_irq   = |(flag_reg & i_irq_en) & ~poff_reg;            // [RULE11] [RULE19]

endmodule

/* File: test/bp_front.sv */
// Purpose: Comparator front end driving the protection block
// Assumes: Fault levels are commanded by the bench
// Notes:   Levels move on the falling edge, away from sampling
`timescale 1ns/100ps
module bp_front (
   input  wire logic             i_clk,   // Clock
   input  wire bp_pkg::bp_cond_t i_fault, // Commanded faults
   output bp_pkg::bp_cond_t      o_cond   // Comparator levels
);
   // Comparators are plain levels; fault stays as long as commanded
   always @(negedge i_clk) o_cond <= i_fault;
endmodule

/* File: test/bp_properties.sv */
// Purpose: Port-level checks of the protection block
// Assumes: Single clock, async active-low reset
// Notes:   Warning lead is counted in clocks at the bound tick rate
`timescale 1ns/100ps
module bp_properties #(
   parameter int US_PER_MS = bp_pkg::US_PER_MS // Ticks per ms
) (
   input wire logic                     i_clk,         // Clock
   input wire logic                     i_reset_n,     // Reset
   input wire logic                     i_charger_det, // Charger
   input wire logic                     i_pwm_active,  // PWM
   input wire bp_pkg::bp_cfg_wr_t       i_cfg_wr,      // Cfg write
   input wire logic                     i_lock_wr,     // Lock write
   input wire logic                     i_param_lock_enable, // Lock en
   input wire logic                     i_param_lock,  // Lock bit
   input wire logic [bp_pkg::FLG_N-1:0] i_irq_en,      // Irq mask
   input wire bp_pkg::bp_cfg_t          o_cfg,         // Cfg
   input wire logic                     o_locked,      // Locked
   input wire bp_pkg::bp_fet_t          o_fet,         // Switches
   input wire logic                     o_balance_allow, // Balance
   input wire logic                     o_power_off,   // Power-off
   input wire bp_pkg::bp_cond_t         o_det_en,      // Detectors
   input wire logic [bp_pkg::FLG_N-1:0] o_flags,       // Flags
   input wire logic                     o_hold_active, // Hold
   input wire logic                     o_irq          // Irq
);
   localparam int WARN_CYC = bp_pkg::DUV_WARN_MS * US_PER_MS * bp_pkg::TICK_CYC;
   int warn_cnt_reg;
   int warn_cnt_next;
   assign warn_cnt_next = o_flags[bp_pkg::FLG_DUVW] ? warn_cnt_reg + 1 : 0;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) warn_cnt_reg <= 0;
      else warn_cnt_reg <= warn_cnt_next;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   property p_trip; $rose(o_flags[bp_pkg::FLG_SC]) |-> o_hold_active && o_fet == '0; endproperty
   a_trip: assert property (p_trip) else $error("switches on at trip");
   property p_hold; o_hold_active |=> o_fet == '0; endproperty
   a_hold: assert property (p_hold) else $error("switch on in hold-off");
   property p_dcd; !o_fet.discharge |-> !o_det_en.sc && !o_det_en.dcoc; endproperty
   a_dcd: assert property (p_dcd) else $error("discharge detect on");
   property p_ccd; !o_fet.charge && !o_fet.precharge && !i_pwm_active |-> !o_det_en.ccoc;
   endproperty
   a_ccd: assert property (p_ccd) else $error("charge detect on");
   property p_pwm;
      i_pwm_active && !o_power_off && !o_cfg.ctrl[bp_pkg::CTRL_CCD] |-> o_det_en.ccoc;
   endproperty
   a_pwm: assert property (p_pwm) else $error("charge detect off under pwm");
   property p_irq; o_irq == (|(o_flags & i_irq_en) && !o_power_off); endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");
   property p_poff; $rose(o_power_off) |-> o_fet == '0 && !o_balance_allow && !o_irq; endproperty
   a_poff: assert property (p_poff) else $error("power-off outputs");
   property p_warn; $rose(o_power_off) |-> warn_cnt_reg == WARN_CYC; endproperty
   a_warn: assert property (p_warn) else $error("warning lead wrong");
   property p_stay; o_power_off && !i_charger_det |=> o_power_off; endproperty
   a_stay: assert property (p_stay) else $error("left power-off");
   property p_restart; o_power_off && i_charger_det |=> !o_power_off && !o_locked && o_cfg == '0;
   endproperty
   a_restart: assert property (p_restart) else $error("restart not clean");
   property p_cfg;
      i_cfg_wr.wr && !o_locked && !o_power_off && i_cfg_wr.sel == bp_pkg::SEL_TIMING
      |=> o_cfg.timing == $past(i_cfg_wr.data);
   endproperty
   a_cfg: assert property (p_cfg) else $error("timing write lost");
   property p_lkd; o_locked && !o_power_off |=> $stable(o_cfg); endproperty
   a_lkd: assert property (p_lkd) else $error("locked cfg changed");
   property p_lock;
      $rose(o_locked) |-> $past(i_lock_wr) && $past(i_param_lock) && !$past(i_param_lock_enable);
   endproperty
   a_lock: assert property (p_lock) else $error("lock without sequence");
   c_trip: cover property ($rose(o_flags[bp_pkg::FLG_SC]));
   c_poff: cover property ($rose(o_power_off));
   c_lock: cover property ($rose(o_locked));
endmodule
bind bp_top bp_properties #(.US_PER_MS(US_PER_MS)) bp_properties_i (.i_clk, .i_reset_n,
   .i_charger_det, .i_pwm_active, .i_cfg_wr, .i_lock_wr, .i_param_lock_enable, .i_param_lock,
   .i_irq_en, .o_cfg, .o_locked, .o_fet, .o_balance_allow, .o_power_off, .o_det_en, .o_flags,
   .o_hold_active, .o_irq);

/* File: test/test_bp_top.sv */
// Purpose: Self-checking bench of the protection block
// Assumes: One ms is shortened to one us tick
// Notes:   Monitor compares queued notes just after each falling edge
`timescale 1ns/100ps
module test_bp_top;
   typedef struct {int s; logic [39:0] e;} bp_note_t;
   logic i_clk = 0, i_reset_n = 0, i_charger_det, i_pwm_active, i_lock_wr;
   logic i_param_lock_enable, i_param_lock, i_fet_wr, o_locked, o_balance_allow;
   logic o_power_off, o_hold_active, o_irq;
   logic [4:0] i_flag_clr, i_irq_en, o_flags;
   logic [31:0] r;
   bp_pkg::bp_cond_t fault, cond, o_det_en;
   bp_pkg::bp_cfg_wr_t i_cfg_wr;
   bp_pkg::bp_fet_t i_fet_data, o_fet;
   bp_pkg::bp_cfg_t o_cfg, ce;
   bp_note_t q[$];
   int n_fail = 0, checks = 0;
   always #25 i_clk = ~i_clk;
   bp_front bp_front_i (.i_clk, .i_fault(fault), .o_cond(cond));
   bp_top #(.US_PER_MS(1)) bp_top_i (.i_clk, .i_reset_n, .i_cond(cond), .i_charger_det,
      .i_pwm_active, .i_cfg_wr, .i_lock_wr, .i_param_lock_enable, .i_param_lock, .i_fet_wr,
      .i_fet_data, .i_flag_clr, .i_irq_en, .o_cfg, .o_locked, .o_fet, .o_balance_allow,
      .o_power_off, .o_det_en, .o_flags, .o_hold_active, .o_irq);
   function automatic logic [39:0] obs(int s);
      case (s)
         0: return o_cfg;
         1: return {37'h0, o_fet};
         2: return {35'h0, o_flags};
         3: return {35'h0, o_irq, o_locked, o_power_off, o_hold_active, o_balance_allow};
         default: return {36'h0, o_det_en};
      endcase
   endfunction
   task automatic note(int s, logic [39:0] e); q.push_back('{s, e}); endtask
   task automatic cyc(int n); repeat (n) @(negedge i_clk); endtask
   task automatic cfg(logic [2:0] s, logic [7:0] d);
      i_cfg_wr = '{1'b1, s, d}; cyc(1); i_cfg_wr.wr = 1'b0; cyc(1);
   endtask
   task automatic fetw(logic [2:0] d); i_fet_wr = 1; i_fet_data = d; cyc(1); i_fet_wr = 0; cyc(1);
   endtask
   task automatic lockw(logic en, logic lk);
      i_lock_wr = 1; i_param_lock_enable = en; i_param_lock = lk; cyc(1); i_lock_wr = 0; cyc(1);
   endtask
   // Bounded wait; running out is a mismatch of its own
   task automatic wait_on(int s, int b, int lim);
      int k = 0;
      while (obs(s)[b] !== 1'b1 && k < lim) begin cyc(1); k++; end
      checks++;
      if (k >= lim) begin n_fail++; $display("mismatch at %0t: exp %h got %h", $time, 1, 0); end
   endtask
   task automatic rst; fault = '0; i_pwm_active = 0; i_reset_n = 0; cyc(3); i_reset_n = 1; ce = '0;
   endtask
   task automatic final_report;
      if (n_fail == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(negedge i_clk) begin
      bp_note_t n;
      #1;
      while (q.size() > 0) begin
         n = q.pop_front();
         checks++;
         if (obs(n.s) !== n.e) begin
            n_fail++;
            $display("mismatch at %0t: exp %h got %h", $time, n.e, obs(n.s));
         end
      end
   end
   initial begin #(50 * 95000); n_fail++; final_report(); end
   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      fault = '0; i_charger_det = 0; i_pwm_active = 0; i_cfg_wr = '0; i_lock_wr = 0;
      i_param_lock_enable = 0; i_param_lock = 0; i_fet_wr = 0; i_fet_data = '0;
      i_flag_clr = '0; i_irq_en = '1; ce = '0;
      void'($urandom(32'hAE1CE307));
      cyc(3); i_reset_n = 1; cyc(1);
      note(3, 5'h01); note(4, 4'h8);
      r = $urandom;
      cfg(bp_pkg::SEL_SCLVL, r[7:0]); cfg(bp_pkg::SEL_DUV, r[15:8] & 8'hCF);
      cfg(bp_pkg::SEL_TIMING, {4'h0, r[19:16]}); cfg(bp_pkg::SEL_CTRL, 8'hF8);
      ce = {8'hF8 & bp_pkg::CTRL_MASK, 4'h0, r[19:16], 8'h00, r[7:0] & bp_pkg::SCLVL_MASK, 8'h00};
      ce.duv = r[15:8] & 8'hCF & bp_pkg::DUV_MASK; note(0, ce);
      fetw(3'h7); note(1, 3'h7); note(4, 4'h7);
      fault.sc = 1; cyc(1200); note(2, 5'h00);
      cyc(80); note(2, 5'h01); note(1, 3'h0); note(3, 5'h13);
      cyc(1); i_irq_en = '0; cyc(1); note(3, 5'h03); cyc(1); i_irq_en = '1;
      fetw(3'h7); note(1, 3'h0);
      i_flag_clr = 5'h01; cyc(1); i_flag_clr = '0; cyc(1); note(2, 5'h00);
      wait_on(2, bp_pkg::FLG_EXIT, 21000); cyc(1); note(3, 5'h11);
      fetw(3'h7); note(1, 3'h7); cyc(1280); note(2, 5'h11); cyc(1);
      rst(); fetw(3'h7); fault.dcoc = 1;
      wait_on(2, bp_pkg::FLG_DCOC, 25000); note(1, 3'h0);
      fault = '0; i_pwm_active = 1; cyc(1); note(4, 4'h9);
      fault.ccoc = 1; wait_on(2, bp_pkg::FLG_CCOC, 25000);
      rst(); lockw(1, 1); cyc(5); lockw(0, 1); note(3, 5'h01);
      lockw(1, 1); lockw(0, 1); note(3, 5'h09);
      cfg(bp_pkg::SEL_TIMING, 8'h5A); note(0, ce);
      fetw(3'h7); fault.duv = 1; wait_on(2, bp_pkg::FLG_DUVW, 16000);
      wait_on(3, 2, 5100); note(1, 3'h0); note(3, 5'h0C);
      fault = '0; i_charger_det = 1; cyc(1); i_charger_det = 0; cyc(1);
      note(3, 5'h01); note(0, 40'h0);
      cyc(2); final_report();
   end
endmodule
